// ---- core/bspnc_pkg.sv ----
package bspnc_pkg;

  localparam int unsigned CLK_PERIOD_NS = 20;
  // NMI base tick and pulse width
  localparam int unsigned NMI_TICK_NS   = 1000;
  localparam int unsigned NMI_TICK_CYC  = NMI_TICK_NS / CLK_PERIOD_NS;
  localparam int unsigned NMI_PULSE_NS  = 200;
  localparam int unsigned NMI_PULSE_CYC = NMI_PULSE_NS / CLK_PERIOD_NS;
  // led half period while blinking
  localparam int unsigned LED_HALF_MS   = 250;
  localparam int unsigned LED_HALF_CYC  = LED_HALF_MS * 1000000 / CLK_PERIOD_NS;

  localparam logic [9:0] ADDR_BOARD_STATUS   = 10'h234;
  localparam logic [9:0] ADDR_SUPPLY_CONTROL = 10'h235;
  localparam logic [9:0] ADDR_NMI_LOW        = 10'h237;
  localparam logic [9:0] ADDR_NMI_HIGH       = 10'h238;

  localparam int unsigned STAT_MAINS_BIT   = 0;
  localparam int unsigned STAT_BATT_BIT    = 1;
  localparam int unsigned STAT_WARN_BIT    = 2;
  localparam int unsigned STAT_RUN_BIT     = 3;
  localparam int unsigned STAT_UPDATE_BIT  = 4;
  localparam int unsigned SUPPLY_OFF_BIT   = 0;

  localparam logic [15:0] NMI_INTERVAL_RST = 16'h0000;
  localparam logic        SUPPLY_OFF_RST   = 1'b0;
  localparam logic [7:0]  RDATA_RST        = 8'h00;

  typedef struct packed {
    logic [9:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } bspnc_io_req_type;

  typedef struct packed {
    logic isa_jumper;
    logic high_intensity;
    logic reset_key;
    logic accu_warn;
    logic batt_low;
    logic mains_good;
    logic update_sw;
    logic run_sw;
  } bspnc_pins_type;

endpackage

// ---- core/bspnc_top.sv ----
`timescale 1ns/100ps
`default_nettype none
module bspnc_top #(
  parameter int unsigned LED_HALF_CYCLES = bspnc_pkg::LED_HALF_CYC
) (
  input  wire logic                        sys_clk_i,
  input  wire logic                        rst_i,
  input  wire bspnc_pkg::bspnc_io_req_type io_req_i,
  input  wire bspnc_pkg::bspnc_pins_type   pins_i,
  output logic [7:0]                       io_rdata_o,
  output logic                             supply_off_line_o,
  output logic                             local_nmi_o,
  output logic                             isa_nmi_o,
  output logic                             local_cpu_reset_o,
  output logic                             tx_led_o
);

  typedef struct packed {
    bspnc_pkg::bspnc_pins_type s1;
    bspnc_pkg::bspnc_pins_type s2;
    bspnc_pkg::bspnc_pins_type s3;
    bspnc_pkg::bspnc_pins_type filt;
    logic [7:0]                rdata;
    logic                      supply_off;
    logic [15:0]               interval;
    logic [15:0]               tick_cnt;
    logic [15:0]               period_cnt;
    logic [15:0]               pulse_left;
    logic                      nmi;
    logic                      isa_nmi;
    logic                      cpu_reset;
    logic [31:0]               led_cnt;
    logic                      led;
  } bspnc_state_type;

  bspnc_state_type r;
  bspnc_state_type next_r;
  logic            fire;
  logic            hit_status;
  logic            hit_supply;
  logic            hit_lo;
  logic            hit_hi;

  function automatic logic io_hit(input logic [9:0] addr, input logic [9:0] target,
                                  input logic strobe);
    io_hit = strobe && (addr == target);
  endfunction

  function automatic logic [7:0] status_byte(input bspnc_pkg::bspnc_pins_type p);
    logic [7:0] s;
    s = 8'h00;
    s[bspnc_pkg::STAT_MAINS_BIT]  = p.mains_good;
    s[bspnc_pkg::STAT_BATT_BIT]   = p.batt_low;
    s[bspnc_pkg::STAT_WARN_BIT]   = p.accu_warn;
    s[bspnc_pkg::STAT_RUN_BIT]    = p.run_sw;
    s[bspnc_pkg::STAT_UPDATE_BIT] = p.update_sw;
    status_byte = s;
  endfunction

  always_comb begin
    next_r = r;
    fire   = 1'b0;
    hit_status = io_hit(io_req_i.addr, bspnc_pkg::ADDR_BOARD_STATUS, io_req_i.rd);
    hit_supply = io_hit(io_req_i.addr, bspnc_pkg::ADDR_SUPPLY_CONTROL, io_req_i.wr);
    hit_lo     = io_hit(io_req_i.addr, bspnc_pkg::ADDR_NMI_LOW, io_req_i.wr);
    hit_hi     = io_hit(io_req_i.addr, bspnc_pkg::ADDR_NMI_HIGH, io_req_i.wr);

    // three stages; a change is taken once the last two agree
    next_r.s1   = pins_i;
    next_r.s2   = r.s1;
    next_r.s3   = r.s2;
    next_r.filt = bspnc_pkg::bspnc_pins_type'((r.s3 & ~(r.s2 ^ r.s3)) |
                                              (r.filt & (r.s2 ^ r.s3)));

    // write-only registers and unmapped addresses read as zero
    next_r.rdata = hit_status ? status_byte(r.filt) : 8'h00;

    // supply off only on software command, after its save is done
    if (hit_supply) begin
      next_r.supply_off = io_req_i.wdata[bspnc_pkg::SUPPLY_OFF_BIT];
    end

    // key drives the local cpu reset only; no host bus reset output exists
    next_r.cpu_reset = r.filt.reset_key;

    // base tick counter, reloaded on every interval write
    if (hit_lo || hit_hi) begin
      if (hit_lo) begin
        next_r.interval[7:0] = io_req_i.wdata;
      end
      if (hit_hi) begin
        next_r.interval[15:8] = io_req_i.wdata;
      end
      next_r.tick_cnt   = 16'h0000;
      next_r.period_cnt = 16'h0000;
    end else if (r.interval == 16'h0000) begin
      next_r.tick_cnt   = 16'h0000;
      next_r.period_cnt = 16'h0000;
    end else if (r.tick_cnt == 16'(bspnc_pkg::NMI_TICK_CYC - 1)) begin
      next_r.tick_cnt = 16'h0000;
      if (r.period_cnt == r.interval - 16'h0001) begin
        next_r.period_cnt = 16'h0000;
        fire              = 1'b1;
      end else begin
        next_r.period_cnt = r.period_cnt + 16'h0001;
      end
    end else begin
      next_r.tick_cnt = r.tick_cnt + 16'h0001;
    end

    // fixed width pulse, shorter than one base tick so pulses never merge
    if (fire) begin
      next_r.nmi        = 1'b1;
      next_r.pulse_left = 16'(bspnc_pkg::NMI_PULSE_CYC - 1);
    end else if (r.pulse_left != 16'h0000) begin
      next_r.pulse_left = r.pulse_left - 16'h0001;
    end else begin
      next_r.nmi = 1'b0;
    end
    next_r.isa_nmi = next_r.nmi && r.filt.isa_jumper;

    // led blinks at high intensity, held dark otherwise
    if (!r.filt.high_intensity) begin
      next_r.led_cnt = 32'h00000000;
      next_r.led     = 1'b0;
    end else if (r.led_cnt == LED_HALF_CYCLES - 1) begin
      next_r.led_cnt = 32'h00000000;
      next_r.led     = ~r.led;
    end else begin
      next_r.led_cnt = r.led_cnt + 32'h00000001;
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      r            <= '0;
      r.rdata      <= bspnc_pkg::RDATA_RST;
      r.supply_off <= bspnc_pkg::SUPPLY_OFF_RST;
      r.interval   <= bspnc_pkg::NMI_INTERVAL_RST;
      r.cpu_reset  <= 1'b1;
    end else begin
      r <= next_r;
    end
  end

  assign io_rdata_o        = r.rdata;
  assign supply_off_line_o = r.supply_off;
  assign local_nmi_o       = r.nmi;
  assign isa_nmi_o         = r.isa_nmi;
  assign local_cpu_reset_o = r.cpu_reset;
  assign tx_led_o          = r.led;

  // helper: cycles between successive NMI starts
  logic [21:0] gap;
  logic        gap_ok;
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      gap    <= 22'h000000;
      gap_ok <= 1'b0;
    end else begin
      gap    <= fire ? 22'h000001 : gap + 22'h000001;
      gap_ok <= (hit_lo || hit_hi) ? 1'b0 : (fire ? 1'b1 : gap_ok);
    end
  end

  // helper: length of the running nmi pulse, kept short of a long repetition
  logic [7:0]  nmi_len;
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      nmi_len <= 8'h00;
    end else begin
      nmi_len <= local_nmi_o ? nmi_len + 8'h01 : 8'h00;
    end
  end

  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (rst_i);

  chk_status_read: assert property (hit_status |=> io_rdata_o == status_byte($past(r.filt)))
    else $error("status read data wrong");
  chk_rdata_idle: assert property (!hit_status |=> io_rdata_o == 8'h00)
    else $error("read data not zero outside status read");
  chk_batt_bit: assert property (hit_status && r.filt.batt_low |=> io_rdata_o[1])
    else $error("battery bit not set");
  chk_mains_bit: assert property (hit_status && !r.filt.mains_good |=> !io_rdata_o[0])
    else $error("mains bit wrong");
  chk_switch_bits: assert property (hit_status |=>
      io_rdata_o[4:3] == {$past(r.filt.update_sw), $past(r.filt.run_sw)})
    else $error("switch bits wrong");
  chk_warn_bit: assert property (hit_status |=> io_rdata_o[2] == $past(r.filt.accu_warn))
    else $error("warning bit wrong");
  chk_reset_follows: assert property (r.filt.reset_key |=> local_cpu_reset_o)
    else $error("local reset missing");
  chk_supply_set: assert property (hit_supply && io_req_i.wdata[0] |=> supply_off_line_o)
    else $error("supply off not driven");
  chk_supply_cause: assert property ($rose(supply_off_line_o) |-> $past(hit_supply))
    else $error("supply off without command");
  chk_supply_clear: assert property (hit_supply && !io_req_i.wdata[0] |=> !supply_off_line_o)
    else $error("supply off not released");
  chk_supply_hold: assert property (!hit_supply |=> $stable(supply_off_line_o))
    else $error("supply off changed without command");
  chk_nmi_disabled: assert property ($rose(local_nmi_o) |-> $past(r.interval) != 16'h0000)
    else $error("nmi while disabled");
  chk_nmi_width: assert property ($fell(local_nmi_o) |-> nmi_len == 8'(bspnc_pkg::NMI_PULSE_CYC))
    else $error("nmi pulse width wrong");
  chk_nmi_period: assert property (fire && gap_ok |->
      gap == 22'({6'h00, r.interval} * 22'(bspnc_pkg::NMI_TICK_CYC)))
    else $error("nmi period wrong");
  chk_isa_nmi: assert property (isa_nmi_o |-> local_nmi_o && $past(r.filt.isa_jumper))
    else $error("host nmi without local nmi");
  chk_isa_follow: assert property (local_nmi_o && $past(r.filt.isa_jumper) |-> isa_nmi_o)
    else $error("host nmi missing with jumper fitted");
  chk_led_dark: assert property (!r.filt.high_intensity |=> !tx_led_o)
    else $error("led lit at low intensity");

  cov_status_read: cover property (hit_status ##1 io_rdata_o != 8'h00);
  cov_supply_off: cover property (!r.filt.mains_good ##[1:100] $rose(supply_off_line_o));
  cov_nmi_repeat: cover property (fire && gap_ok);
  cov_isa_nmi: cover property ($rose(isa_nmi_o));
  cov_led_blink: cover property ($rose(tx_led_o));

endmodule
`default_nettype wire

// ---- sim/board_status_power_nmi_ctrl_bench.sv ----
`timescale 1ns/100ps
`default_nettype none
module board_status_power_nmi_ctrl_bench;
  logic                        sys_clk_i = 1'b0;
  logic                        rst_i = 1'b1;
  bspnc_pkg::bspnc_io_req_type io_req;
  bspnc_pkg::bspnc_pins_type   pins = '0;
  logic [7:0]                  rdata;
  logic [7:0]                  d;
  logic                        off, lnmi, inmi, cpu_rst, led;
  int                          err_count = 0;
  int                          comparisons = 0;
  int                          n;
  logic [9:0]                  refused_addr [4] = '{10'h235, 10'h237, 10'h238, 10'h233};
  always #10 sys_clk_i = ~sys_clk_i;
  bspnc_top #(.LED_HALF_CYCLES(8)) i_bspnc_top (
    .sys_clk_i(sys_clk_i), .rst_i(rst_i), .io_req_i(io_req), .pins_i(pins),
    .io_rdata_o(rdata), .supply_off_line_o(off), .local_nmi_o(lnmi),
    .isa_nmi_o(inmi), .local_cpu_reset_o(cpu_rst), .tx_led_o(led));
  bspnc_cpu_model i_bspnc_cpu_model (.clk_i(sys_clk_i), .rdata_i(rdata), .req_o(io_req));
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic stop_test();
    $display("comparisons %0d err_count %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // bounded wait for a rising nmi; n returns lim when none came
  task automatic wait_nmi(input int lim, output int k);
    k = 0;
    while (k < lim && lnmi !== 1'b1) begin
      @(posedge sys_clk_i);
      #1;
      k++;
    end
  endtask
  task automatic settle();
    repeat (6) @(negedge sys_clk_i);
  endtask
  initial begin
    #100us;
    err_count++;
    stop_test();
  end
  initial begin
    repeat (2) @(negedge sys_clk_i);
    check(rdata, 8'h00);
    check({3'h0, off, lnmi, inmi, led, cpu_rst}, 8'h01);
    rst_i = 1'b0;
    for (int i = 0; i < 32; i++) begin
      {pins.update_sw, pins.run_sw, pins.accu_warn, pins.batt_low, pins.mains_good} = 5'(i);
      settle();
      i_bspnc_cpu_model.rd(10'h234, d);
      check(d, 8'(i));
    end
    foreach (refused_addr[j]) begin
      i_bspnc_cpu_model.rd(refused_addr[j], d);
      check(d, 8'h00);
    end
    i_bspnc_cpu_model.rd(10'h235, d);
    check(d, 8'h00);
    i_bspnc_cpu_model.wr(10'h236, 8'h01);
    check({7'h0, off}, 8'h00);
    pins.mains_good = 1'b0;
    settle();
    i_bspnc_cpu_model.rd(10'h234, d);
    check(d, 8'h1E);
    i_bspnc_cpu_model.wr(10'h235, 8'h01);
    check({7'h0, off}, 8'h01);
    i_bspnc_cpu_model.wr(10'h235, 8'hFE);
    check({7'h0, off}, 8'h00);
    pins.isa_jumper = 1'b1;
    i_bspnc_cpu_model.wr(10'h238, 8'h00);
    i_bspnc_cpu_model.wr(10'h237, 8'h01);
    wait_nmi(200, n);
    check(8'(n), 8'h32);
    check({7'h0, inmi}, 8'h01);
    n = 0;
    do begin
      @(posedge sys_clk_i);
      #1;
      n++;
    end while (lnmi === 1'b1 && n < 20);
    check(8'(n), 8'd10);
    @(negedge sys_clk_i);
    pins.isa_jumper = 1'b0;
    wait_nmi(200, n);
    check(8'(n), 8'h28);
    check({7'h0, inmi}, 8'h00);
    settle();
    settle();
    i_bspnc_cpu_model.wr(10'h237, 8'h00);
    wait_nmi(150, n);
    check(8'(n), 8'd150);
    i_bspnc_cpu_model.wr(10'h235, 8'h01);
    i_bspnc_cpu_model.wr(10'h237, 8'h01);
    @(negedge sys_clk_i);
    rst_i = 1'b1;
    repeat (2) @(negedge sys_clk_i);
    rst_i = 1'b0;
    check({7'h0, off}, 8'h00);
    wait_nmi(150, n);
    check(8'(n), 8'h96);
    @(negedge sys_clk_i);
    pins.reset_key = 1'b1;
    settle();
    check({6'h0, inmi, cpu_rst}, 8'h01);
    pins.reset_key = 1'b0;
    pins.high_intensity = 1'b1;
    settle();
    check({7'h0, cpu_rst}, 8'h00);
    n = 0;
    repeat (32) begin
      d[0] = led;
      @(negedge sys_clk_i);
      n += int'(d[0] !== led);
    end
    check(8'(n), 8'd4);
    n = 0;
    while (led !== 1'b1 && n < 10) begin
      @(negedge sys_clk_i);
      n++;
    end
    check({7'h0, led}, 8'h01);
    pins.high_intensity = 1'b0;
    settle();
    check({7'h0, led}, 8'h00);
    stop_test();
  end
endmodule
`default_nettype wire

// ---- sim/bspnc_cpu_model.sv ----
`timescale 1ns/100ps
`default_nettype none
module bspnc_cpu_model (
  input  wire logic                   clk_i,
  input  wire logic [7:0]             rdata_i,
  output var  bspnc_pkg::bspnc_io_req_type req_o
);
  initial req_o = '0;
  // supply-off is only issued by software after its save is done
  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    @(negedge clk_i);
    req_o = '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(negedge clk_i);
    req_o.wr = 1'b0;
  endtask
  task automatic rd(input logic [9:0] a, output logic [7:0] d);
    @(negedge clk_i);
    req_o = '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(negedge clk_i);
    req_o.rd = 1'b0;
    d = rdata_i;
  endtask
endmodule
`default_nettype wire
